// [acc_regs.vh]
// Register map and field constants of the two-instance comparator control block
`ifndef ACC_REGS_VH
`define ACC_REGS_VH

// Byte addresses, one aligned word per register (x = 0 for comparator 1, 1 for comparator 2)
`define ACC_ADDR_W          6
`define ACC_OFS_CTRL0       6'h00
`define ACC_OFS_EDGE1       6'h04
`define ACC_OFS_PSEL0       6'h08
`define ACC_OFS_NSEL0       6'h0C
`define ACC_OFS_CTRL1       6'h10
`define ACC_OFS_EDGE2       6'h14
`define ACC_OFS_PSEL1       6'h18
`define ACC_OFS_NSEL1       6'h1C
`define ACC_OFS_SHARED      6'h20
`define ACC_OFS_IRQ_FLAG    6'h24
`define ACC_OFS_IRQ_EN      6'h28
`define ACC_OFS_ADC_TRIG    6'h2C

// Fields of the main control register
`define ACC_CTL_EN          7
`define ACC_CTL_OUT         6
`define ACC_CTL_POL         4
`define ACC_CTL_ONE         2
`define ACC_CTL_HYS         1
`define ACC_CTL_SYNC        0

// Fields of the edge control register
`define ACC_EDGE_RISE       1
`define ACC_EDGE_FALL       0

// Channel select width and adc trigger field width
`define ACC_SEL_W           3
`define ACC_TRIG_W          5
`define ACC_TRIG_CMP1       5'h13
`define ACC_TRIG_CMP2       5'h14

// Reset values
`define ACC_RST_SEL         3'h0
`define ACC_RST_TRIG        5'h00

// AXI responses
`define ACC_RESP_OKAY       2'h0
`define ACC_RESP_SLVERR     2'h2

`endif

// [acc_channel.v]
// One comparator channel: polarity, internal latch, sync latch and edge detection
`timescale 1ns/1ps
`default_nettype none

module acc_channel (
    input  wire       clk,
    input  wire       resetn,
    input  wire       raw_sync,
    input  wire       enable,
    input  wire       invert_output_sel,
    input  wire       sync_mode,
    input  wire       t1_fall,
    input  wire       rise_edge_irq_enable,
    input  wire       fall_edge_irq_enable,
    output reg        cmp_result_bit,
    output reg        ext_out,
    output wire       irq_event,
    output wire       rise_event
);

    reg  prev_result;
    wire cmp_value;
    wire next_result;

    // Disabled comparator reads low before inversion, so EN or polarity toggles make edges
    assign cmp_value   = (enable & raw_sync) ^ invert_output_sel;
    assign next_result = sync_mode ? (t1_fall ? cmp_value : cmp_result_bit) : cmp_value;

    // Internal result latched each clock cycle, in sync mode only on a Timer1 falling edge
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmp_result_bit <= 1'b0;
            prev_result    <= 1'b0;
            ext_out        <= 1'b0;
        end else begin
            cmp_result_bit <= next_result;
            prev_result    <= cmp_result_bit;
            ext_out        <= sync_mode ? next_result : cmp_value;
        end
    end

    // Edge detection on latched, polarity-adjusted result
    assign rise_event = cmp_result_bit & ~prev_result;
    assign irq_event  = (rise_event & rise_edge_irq_enable) |
                        (~cmp_result_bit & prev_result & fall_edge_irq_enable);

endmodule

`default_nettype wire

// [acc_top.v]
// Top level of the comparator control block with its AXI4-Lite register slave
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"

module acc_top #(
    parameter NCMP = 2
) (
    input  wire                   SYS_CLK,
    input  wire                   RESETN,
    input  wire [NCMP-1:0]        CMP_RAW,
    input  wire                   T1_CLK,
    output reg  [NCMP-1:0]        CMP_EXT_OUT,
    output reg  [NCMP-1:0]        CMP_POWER_EN,
    output reg  [NCMP-1:0]        INPUT_SEPARATION_EN,
    output reg  [NCMP*3-1:0]      CMP_PLUS_CH,
    output reg  [NCMP*3-1:0]      CMP_MINUS_CH,
    output reg  [NCMP-1:0]        CMP_INPUTS_CONNECT,
    output reg  [NCMP-1:0]        CMP_IRQ,
    output reg                    ADC_START,
    input  wire [5:0]             S_AXI_AWADDR,
    input  wire                   S_AXI_AWVALID,
    output reg                    S_AXI_AWREADY,
    input  wire [31:0]            S_AXI_WDATA,
    input  wire [3:0]             S_AXI_WSTRB,
    input  wire                   S_AXI_WVALID,
    output reg                    S_AXI_WREADY,
    output reg  [1:0]             S_AXI_BRESP,
    output reg                    S_AXI_BVALID,
    input  wire                   S_AXI_BREADY,
    input  wire [5:0]             S_AXI_ARADDR,
    input  wire                   S_AXI_ARVALID,
    output reg                    S_AXI_ARREADY,
    output reg  [31:0]            S_AXI_RDATA,
    output reg  [1:0]             S_AXI_RRESP,
    output reg                    S_AXI_RVALID,
    input  wire                   S_AXI_RREADY
);

    ////////////////////////////////////////////////////////////////////////////////
    // Control state
    reg  [NCMP-1:0]      en_bit;
    reg  [NCMP-1:0]      pol_bit;
    reg  [NCMP-1:0]      hys_bit;
    reg  [NCMP-1:0]      sync_bit;
    reg  [NCMP-1:0]      rise_en;
    reg  [NCMP-1:0]      fall_en;
    reg  [NCMP*3-1:0]    psel;
    reg  [NCMP*3-1:0]    nsel;
    reg  [NCMP-1:0]      irq_flag;
    reg  [NCMP-1:0]      irq_enable;
    reg  [4:0]           adc_trigger_select;

    // Synchronisers for asynchronous comparator outputs and the Timer1 clock
    reg  [NCMP-1:0]      raw_meta;
    reg  [NCMP-1:0]      raw_sync;
    reg                  t1_meta;
    reg                  t1_sync;
    reg                  t1_prev;
    wire                 t1_fall;

    wire [NCMP-1:0]      result;
    wire [NCMP-1:0]      ext_val;
    wire [NCMP-1:0]      irq_event;
    wire [NCMP-1:0]      rise_event;

    // Two flops on the comparator outputs and three on the Timer1 clock, the last for edge detection
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            raw_meta <= {NCMP{1'b0}};
            raw_sync <= {NCMP{1'b0}};
            t1_meta  <= 1'b0;
            t1_sync  <= 1'b0;
            t1_prev  <= 1'b0;
        end else begin
            raw_meta <= CMP_RAW;
            raw_sync <= raw_meta;
            t1_meta  <= T1_CLK;
            t1_sync  <= t1_meta;
            t1_prev  <= t1_sync;
        end
    end

    assign t1_fall = t1_prev & ~t1_sync;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator channels
    genvar gi;
    generate
        for (gi = 0; gi < NCMP; gi = gi + 1) begin : g_ch
            acc_channel u_ch (
                .clk                  (SYS_CLK),
                .resetn               (RESETN),
                .raw_sync             (raw_sync[gi]),
                .enable               (en_bit[gi]),
                .invert_output_sel    (pol_bit[gi]),
                .sync_mode            (sync_bit[gi]),
                .t1_fall              (t1_fall),
                .rise_edge_irq_enable (rise_en[gi]),
                .fall_edge_irq_enable (fall_en[gi]),
                .cmp_result_bit       (result[gi]),
                .ext_out              (ext_val[gi]),
                .irq_event            (irq_event[gi]),
                .rise_event           (rise_event[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data accepted in either order
    reg                  aw_held;
    reg                  w_held;
    reg  [5:0]           aw_addr;
    reg  [31:0]          w_data;
    reg  [3:0]           w_strb;
    wire                 wr_fire;
    wire                 wr_lane0;
    wire [7:0]           wb;
    wire [NCMP-1:0]      flag_clear;
    reg                  wr_hit;

    assign wr_fire  = aw_held & w_held & ~S_AXI_BVALID;
    assign wr_lane0 = wr_fire & w_strb[0];
    assign wb       = w_data[7:0];
    // Writing a 1 to a flag bit clears it
    assign flag_clear = (wr_lane0 && aw_addr == `ACC_OFS_IRQ_FLAG) ? wb[NCMP-1:0] : {NCMP{1'b0}};

    // Decode of mapped write addresses
    always @* begin
        case (aw_addr)
            `ACC_OFS_CTRL0, `ACC_OFS_EDGE1, `ACC_OFS_PSEL0, `ACC_OFS_NSEL0,
            `ACC_OFS_CTRL1, `ACC_OFS_EDGE2, `ACC_OFS_PSEL1, `ACC_OFS_NSEL1,
            `ACC_OFS_SHARED, `ACC_OFS_IRQ_FLAG, `ACC_OFS_IRQ_EN, `ACC_OFS_ADC_TRIG: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write handshake and response
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 6'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `ACC_RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= ~aw_held & ~S_AXI_AWREADY & S_AXI_AWVALID;
            S_AXI_WREADY  <= ~w_held & ~S_AXI_WREADY & S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= {S_AXI_AWADDR[5:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_bit             <= {NCMP{1'b0}};
            pol_bit            <= {NCMP{1'b0}};
            hys_bit            <= {NCMP{1'b0}};
            sync_bit           <= {NCMP{1'b0}};
            rise_en            <= {NCMP{1'b0}};
            fall_en            <= {NCMP{1'b0}};
            psel               <= {NCMP{`ACC_RST_SEL}};
            nsel               <= {NCMP{`ACC_RST_SEL}};
            irq_enable         <= {NCMP{1'b0}};
            adc_trigger_select <= `ACC_RST_TRIG;
        end else if (wr_lane0) begin
            case (aw_addr)
                `ACC_OFS_CTRL0: begin
                    en_bit[0]   <= wb[`ACC_CTL_EN];
                    pol_bit[0]  <= wb[`ACC_CTL_POL];
                    hys_bit[0]  <= wb[`ACC_CTL_HYS];
                    sync_bit[0] <= wb[`ACC_CTL_SYNC];
                end
                `ACC_OFS_CTRL1: begin
                    en_bit[1]   <= wb[`ACC_CTL_EN];
                    pol_bit[1]  <= wb[`ACC_CTL_POL];
                    hys_bit[1]  <= wb[`ACC_CTL_HYS];
                    sync_bit[1] <= wb[`ACC_CTL_SYNC];
                end
                `ACC_OFS_EDGE1: begin
                    rise_en[0] <= wb[`ACC_EDGE_RISE];
                    fall_en[0] <= wb[`ACC_EDGE_FALL];
                end
                `ACC_OFS_EDGE2: begin
                    rise_en[1] <= wb[`ACC_EDGE_RISE];
                    fall_en[1] <= wb[`ACC_EDGE_FALL];
                end
                `ACC_OFS_PSEL0: psel[2:0] <= wb[2:0];
                `ACC_OFS_PSEL1: psel[5:3] <= wb[2:0];
                `ACC_OFS_NSEL0: nsel[2:0] <= wb[2:0];
                `ACC_OFS_NSEL1: nsel[5:3] <= wb[2:0];
                `ACC_OFS_IRQ_EN: irq_enable <= wb[NCMP-1:0];
                `ACC_OFS_ADC_TRIG: adc_trigger_select <= wb[4:0];
                default: ;
            endcase
        end
    end

    // Sticky flags: a new edge wins over a clearing write
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_flag <= {NCMP{1'b0}};
        end else begin
            irq_flag <= (irq_flag & ~flag_clear) | irq_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path
    reg  [31:0] rd_word;
    reg         rd_hit;

    // Read mux
    always @* begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case ({S_AXI_ARADDR[5:2], 2'b00})
            `ACC_OFS_CTRL0: rd_word[7:0] = {en_bit[0], result[0], 1'b0, pol_bit[0], 2'b01, hys_bit[0], sync_bit[0]};
            `ACC_OFS_CTRL1: rd_word[7:0] = {en_bit[1], result[1], 1'b0, pol_bit[1], 2'b01, hys_bit[1], sync_bit[1]};
            `ACC_OFS_EDGE1: rd_word[1:0] = {rise_en[0], fall_en[0]};
            `ACC_OFS_EDGE2: rd_word[1:0] = {rise_en[1], fall_en[1]};
            `ACC_OFS_PSEL0: rd_word[2:0] = psel[2:0];
            `ACC_OFS_PSEL1: rd_word[2:0] = psel[5:3];
            `ACC_OFS_NSEL0: rd_word[2:0] = nsel[2:0];
            `ACC_OFS_NSEL1: rd_word[2:0] = nsel[5:3];
            `ACC_OFS_SHARED: rd_word[NCMP-1:0] = result;
            `ACC_OFS_IRQ_FLAG: rd_word[NCMP-1:0] = irq_flag;
            `ACC_OFS_IRQ_EN: rd_word[NCMP-1:0] = irq_enable;
            `ACC_OFS_ADC_TRIG: rd_word[4:0] = adc_trigger_select;
            default: rd_hit = 1'b0;
        endcase
    end

    // Read handshake: one cycle address accept, data the next
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= `ACC_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_word;
                S_AXI_RRESP  <= rd_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Analog control and event outputs, all registered
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CMP_EXT_OUT         <= {NCMP{1'b0}};
            CMP_POWER_EN        <= {NCMP{1'b0}};
            INPUT_SEPARATION_EN <= {NCMP{1'b0}};
            CMP_PLUS_CH         <= {NCMP{`ACC_RST_SEL}};
            CMP_MINUS_CH        <= {NCMP{`ACC_RST_SEL}};
            CMP_INPUTS_CONNECT  <= {NCMP{1'b0}};
            CMP_IRQ             <= {NCMP{1'b0}};
            ADC_START           <= 1'b0;
        end else begin
            CMP_EXT_OUT         <= ext_val;
            CMP_POWER_EN        <= en_bit;
            INPUT_SEPARATION_EN <= hys_bit;
            CMP_PLUS_CH         <= psel;
            CMP_MINUS_CH        <= nsel;
            CMP_INPUTS_CONNECT  <= en_bit;
            CMP_IRQ             <= irq_flag & irq_enable;
            ADC_START           <= (adc_trigger_select == `ACC_TRIG_CMP1 && rise_event[0]) ||
                                   (adc_trigger_select == `ACC_TRIG_CMP2 && rise_event[1]);
        end
    end

endmodule

`default_nettype wire

// [acc_top_assertions.sv]
// Concurrent checks on the ports of the comparator control block
`timescale 1ns/1ps
`default_nettype none

module acc_checker #(
    parameter NCMP = 2
) (
    input wire logic              SYS_CLK,
    input wire logic              RESETN,
    input wire logic [NCMP-1:0]   CMP_POWER_EN,
    input wire logic [NCMP-1:0]   INPUT_SEPARATION_EN,
    input wire logic [NCMP*3-1:0] CMP_PLUS_CH,
    input wire logic [NCMP*3-1:0] CMP_MINUS_CH,
    input wire logic [NCMP-1:0]   CMP_INPUTS_CONNECT,
    input wire logic              ADC_START,
    input wire logic [5:0]        S_AXI_AWADDR,
    input wire logic              S_AXI_AWVALID,
    input wire logic              S_AXI_AWREADY,
    input wire logic              S_AXI_WVALID,
    input wire logic              S_AXI_WREADY,
    input wire logic [1:0]        S_AXI_BRESP,
    input wire logic              S_AXI_BVALID,
    input wire logic              S_AXI_BREADY,
    input wire logic [5:0]        S_AXI_ARADDR,
    input wire logic              S_AXI_ARVALID,
    input wire logic              S_AXI_ARREADY,
    input wire logic [31:0]       S_AXI_RDATA,
    input wire logic [1:0]        S_AXI_RRESP,
    input wire logic              S_AXI_RVALID
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    ////////////////////////////////////////////////////////////////////////////////
    // Analog side follows the control registers
    property p_connect; CMP_INPUTS_CONNECT == CMP_POWER_EN; endproperty
    a_connect: assert property (p_connect) else $error("input connect differs from enable");
    property p_pwr_wr; $changed(CMP_POWER_EN) |-> S_AXI_BVALID || $past(S_AXI_BVALID); endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("enable moved without a write");
    property p_hys_wr; $changed(INPUT_SEPARATION_EN) |-> S_AXI_BVALID || $past(S_AXI_BVALID); endproperty
    a_hys_wr: assert property (p_hys_wr) else $error("hysteresis moved without a write");
    property p_sel_wr; $changed({CMP_PLUS_CH, CMP_MINUS_CH}) |-> S_AXI_BVALID || $past(S_AXI_BVALID); endproperty
    a_sel_wr: assert property (p_sel_wr) else $error("channel select moved without a write");
    property p_adc; ADC_START |=> !ADC_START; endproperty
    a_adc: assert property (p_adc) else $error("conversion start longer than one cycle");

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus answers
    property p_rd_time; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rd_time: assert property (p_rd_time) else $error("read data late");
    // Low address bits are ignored, so only the word index decides what is unmapped
    property p_rd_err; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[5:2] > 4'hB
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0000_0000; endproperty
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    property p_wr_err; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_AWADDR[5:2] > 4'hB
        |-> ##[1:4] S_AXI_BVALID && S_AXI_BRESP == 2'h2; endproperty
    a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
    property p_b_time; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |=> ##1 S_AXI_BVALID ##1 (S_AXI_BVALID || $past(S_AXI_BREADY)); endproperty
    a_b_time: assert property (p_b_time) else $error("write response late");
endmodule

bind acc_top acc_checker #(.NCMP(NCMP)) u_chk (
    .SYS_CLK, .RESETN, .CMP_POWER_EN, .INPUT_SEPARATION_EN, .CMP_PLUS_CH, .CMP_MINUS_CH,
    .CMP_INPUTS_CONNECT, .ADC_START, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID
);
`default_nettype wire

// [acc_tb.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.vh"

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module testbench;
    logic        SYS_CLK = 1'b0;
    logic        RESETN = 1'b0;
    logic [1:0]  CMP_RAW = 2'h0;
    logic        T1_CLK = 1'b1;
    logic [5:0]  S_AXI_AWADDR = 6'h00, S_AXI_ARADDR = 6'h00;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000;
    logic [3:0]  S_AXI_WSTRB = 4'h0;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    wire  [1:0]  CMP_EXT_OUT, CMP_POWER_EN, INPUT_SEPARATION_EN, CMP_INPUTS_CONNECT, CMP_IRQ;
    wire  [5:0]  CMP_PLUS_CH, CMP_MINUS_CH;
    wire         ADC_START, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    wire  [31:0] S_AXI_RDATA;
    int          n_fail = 0;
    int          num_checks = 0;
    int          n_adc = 0;

    acc_top #(.NCMP(2)) uut (
        .SYS_CLK, .RESETN, .CMP_RAW, .T1_CLK, .CMP_EXT_OUT, .CMP_POWER_EN, .INPUT_SEPARATION_EN,
        .CMP_PLUS_CH, .CMP_MINUS_CH, .CMP_INPUTS_CONNECT, .CMP_IRQ, .ADC_START, .S_AXI_AWADDR,
        .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
        .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
        .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY
    );

    // Clock and conversion start counter
    initial begin
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        if (ADC_START === 1'b1) n_adc <= n_adc + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask

    // Write with address and data offered together, each released once taken
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = `ACC_RESP_OKAY,
                      input logic [3:0] s = 4'h1);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge SYS_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h00_0000, d};
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            aw = aw | (S_AXI_AWVALID & S_AXI_AWREADY);
            w = w | (S_AXI_WVALID & S_AXI_WREADY);
            S_AXI_AWVALID <= S_AXI_AWVALID & ~S_AXI_AWREADY;
            S_AXI_WVALID <= S_AXI_WVALID & ~S_AXI_WREADY;
        end while (S_AXI_BVALID !== 1'b1);
        S_AXI_BREADY <= 1'b0;
        `CHK("bresp", er, S_AXI_BRESP);
        `CHK("taken", 2'b11, {aw, w});
    endtask

    // Read one word and compare the masked data
    task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er = `ACC_RESP_OKAY);
        @(posedge SYS_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            S_AXI_ARVALID <= S_AXI_ARVALID & ~S_AXI_ARREADY;
        end while (S_AXI_RVALID !== 1'b1);
        S_AXI_RREADY <= 1'b0;
        `CHK("rresp", er, S_AXI_RRESP);
        `CHK("rdata", e, S_AXI_RDATA & m);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        `CHK("outs", 19'h0_0000, {CMP_EXT_OUT, CMP_POWER_EN, CMP_IRQ, ADC_START, CMP_PLUS_CH, CMP_MINUS_CH});
        for (int i = 0; i < 12; i++) begin
            rd(6'(i * 4), 32'hFFFF_FFFF, (i == 0 || i == 4) ? 32'h0000_0004 : 32'h0000_0000);
        end
        rd(6'h30, 32'hFFFF_FFFF, 32'h0000_0000, `ACC_RESP_SLVERR);
        wr(6'h34, 8'h01, `ACC_RESP_SLVERR);
    endtask

    task automatic t_regs;
        wr(`ACC_OFS_CTRL0, 8'h82);
        wr(`ACC_OFS_CTRL1, 8'h02);
        wr(`ACC_OFS_PSEL0, 8'h05);
        wr(`ACC_OFS_NSEL0, 8'h03);
        wr(`ACC_OFS_PSEL1, 8'h06);
        wr(`ACC_OFS_NSEL1, 8'h07);
        wr(`ACC_OFS_PSEL0, 8'h02, `ACC_RESP_OKAY, 4'h0);
        cyc(2);
        `CHK("power", 2'b01, CMP_POWER_EN);
        `CHK("hys", 2'b11, INPUT_SEPARATION_EN);
        `CHK("connect", 2'b01, CMP_INPUTS_CONNECT);
        `CHK("plus", 6'h35, CMP_PLUS_CH);
        `CHK("minus", 6'h3B, CMP_MINUS_CH);
        rd(`ACC_OFS_PSEL0, 32'hFFFF_FFFF, 32'h0000_0005);
        rd(`ACC_OFS_CTRL1, 32'hFFFF_FFFF, 32'h0000_0006);
        wr(`ACC_OFS_CTRL0, 8'h00);
        wr(`ACC_OFS_CTRL1, 8'h00);
        cyc(2);
        `CHK("off", 4'h0, {CMP_POWER_EN, CMP_INPUTS_CONNECT});
    endtask

    // Every raw level under both polarities, on both comparators
    task automatic t_pol;
        for (int k = 0; k < 4; k++) begin
            wr(`ACC_OFS_CTRL0, k[1] ? 8'h90 : 8'h80);
            wr(`ACC_OFS_CTRL1, k[1] ? 8'h90 : 8'h80);
            CMP_RAW <= {2{k[0]}};
            cyc(8);
            `CHK("ext", {2{k[0] ^ k[1]}}, CMP_EXT_OUT);
            rd(`ACC_OFS_CTRL0, 32'h0000_0040, {25'h0, k[0] ^ k[1], 6'h00});
            rd(`ACC_OFS_SHARED, 32'h0000_0003, {30'h0, {2{k[0] ^ k[1]}}});
        end
    endtask

    // Rising and falling edges against each edge enable, then masking
    task automatic t_irq;
        wr(`ACC_OFS_CTRL0, 8'h80);
        wr(`ACC_OFS_CTRL1, 8'h00);
        CMP_RAW <= 2'b00;
        cyc(8);
        wr(`ACC_OFS_IRQ_EN, 8'h01);
        for (int j = 0; j < 4; j++) begin
            wr(`ACC_OFS_EDGE1, (j < 2) ? 8'h02 : 8'h01);
            wr(`ACC_OFS_IRQ_FLAG, 8'h03);
            CMP_RAW <= {1'b0, ~j[0]};
            cyc(8);
            `CHK("irq", (j == 0 || j == 3), CMP_IRQ[0]);
            rd(`ACC_OFS_IRQ_FLAG, 32'h0000_0001, {31'h0, (j == 0 || j == 3)});
        end
        wr(`ACC_OFS_IRQ_EN, 8'h00);
        cyc(2);
        `CHK("masked", 1'b0, CMP_IRQ[0]);
        rd(`ACC_OFS_IRQ_FLAG, 32'h0000_0001, 32'h0000_0001);
        // Rising edge timed to reach the flag at the edge that applies the clear
        wr(`ACC_OFS_EDGE1, 8'h02);
        CMP_RAW <= 2'b01;
        wr(`ACC_OFS_IRQ_FLAG, 8'h01);
        rd(`ACC_OFS_IRQ_FLAG, 32'h0000_0001, 32'h0000_0001);
    endtask

    // Edges made by polarity and enable while disabled
    task automatic t_dis;
        wr(`ACC_OFS_EDGE1, 8'h02);
        wr(`ACC_OFS_CTRL0, 8'h00);
        CMP_RAW <= 2'b01;
        cyc(8);
        wr(`ACC_OFS_IRQ_FLAG, 8'h03);
        cyc(6);
        rd(`ACC_OFS_IRQ_FLAG, 32'h0000_0001, 32'h0000_0000);
        wr(`ACC_OFS_CTRL0, 8'h10);
        cyc(6);
        rd(`ACC_OFS_IRQ_FLAG, 32'h0000_0001, 32'h0000_0001);
        wr(`ACC_OFS_CTRL0, 8'h00);
        cyc(6);
        wr(`ACC_OFS_IRQ_FLAG, 8'h03);
        wr(`ACC_OFS_CTRL0, 8'h80);
        cyc(6);
        rd(`ACC_OFS_IRQ_FLAG, 32'h0000_0001, 32'h0000_0001);
    endtask

    // Conversion starts only from the selected comparator
    task automatic t_adc;
        int base;
        CMP_RAW <= 2'b00;
        cyc(8);
        wr(`ACC_OFS_ADC_TRIG, 8'h13);
        base = n_adc;
        CMP_RAW <= 2'b01;
        cyc(10);
        `CHK("adc1", 1, n_adc - base);
        CMP_RAW <= 2'b00;
        cyc(8);
        wr(`ACC_OFS_ADC_TRIG, 8'h14);
        base = n_adc;
        CMP_RAW <= 2'b01;
        cyc(10);
        `CHK("adc2", 0, n_adc - base);
        wr(`ACC_OFS_CTRL1, 8'h80);
        base = n_adc;
        CMP_RAW <= 2'b11;
        cyc(10);
        `CHK("adc3", 1, n_adc - base);
        rd(`ACC_OFS_ADC_TRIG, 32'h0000_001F, 32'h0000_0014);
    endtask

    // Result held until a timer clock falling edge
    task automatic t_sync;
        wr(`ACC_OFS_CTRL0, 8'h81);
        T1_CLK <= 1'b0;
        cyc(4);
        T1_CLK <= 1'b1;
        cyc(4);
        CMP_RAW <= 2'b00;
        cyc(10);
        rd(`ACC_OFS_CTRL0, 32'h0000_0040, 32'h0000_0040);
        `CHK("hold", 1'b1, CMP_EXT_OUT[0]);
        T1_CLK <= 1'b0;
        cyc(8);
        rd(`ACC_OFS_CTRL0, 32'h0000_0040, 32'h0000_0000);
        `CHK("sync", 1'b0, CMP_EXT_OUT[0]);
        T1_CLK <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog
    task automatic wrap_up;
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        RESETN <= 1'b1;
        cyc(1);
        t_reset;
        t_regs;
        t_pol;
        t_irq;
        t_dis;
        t_adc;
        t_sync;
        wrap_up;
    end

    initial begin
        #500000;
        n_fail++;
        wrap_up;
    end
endmodule
`default_nettype wire
